//--- hw/dhp_pkg.sv
// constants shared by the downstream hot-plug controller files
// assumes a 125 MHz core clock and a plain address/strobe register port
package dhp_pkg;
    localparam int CLK_KHZ = 125000;

    // register byte offsets
    localparam logic [7:0] OFF_SLOTCAP = 8'h00;
    localparam logic [7:0] OFF_SLOTCTL = 8'h04;
    localparam logic [7:0] OFF_SLOTSTS = 8'h08;
    localparam logic [7:0] OFF_HPCFG = 8'h0c;
    localparam logic [7:0] OFF_POWER_MGMT_CTRL_STATUS_REG = 8'h10;
    localparam logic [7:0] OFF_PMETMR = 8'h14;

    // slot capabilities fields
    localparam int CAP_HPC = 0;
    localparam int CAP_LATCH = 1;
    // slot control fields; bits 4:0 are the event masks, same layout as status
    localparam int CTL_HOT_PLUG_INT_ENABLE_BIT = 5;
    localparam int CTL_ATTN = 6;
    localparam int CTL_PWRI = 8;
    localparam int CTL_PCC = 10;
    localparam int CTL_EIC = 11;
    // slot status fields
    localparam int EV_BTN = 0;
    localparam int EV_FAULT = 1;
    localparam int EV_LATCH = 2;
    localparam int EV_PRES = 3;
    localparam int EV_CC = 4;
    localparam int STS_LATCHST = 5;
    localparam int STS_PRESST = 6;
    localparam int STS_ILOCKST = 7;
    localparam int STS_PGOOD = 8;
    // hot-plug configuration fields; 8:0 are polarity inversions
    localparam int CFG_TOGGLE = 9;
    localparam int CFG_LATCHILK = 10;
    localparam int CFG_AUTOOFF = 11;
    // power management control/status fields
    localparam int PM_EN = 8;
    localparam int PM_STATUS = 15;
    localparam logic [1:0] PM_D3HOT = 2'h3;

    // reset values
    localparam logic [1:0] SLOTCAP_RST = 2'h0;
    localparam logic [10:0] SLOTCTL_RST = 11'h400;
    localparam logic [11:0] HPCFG_RST = 12'h000;
    localparam logic [15:0] PMETMR_RST = 16'h0064;

    // timing
    localparam int ILOCK_MIN_MS = 100;
    localparam int ILOCK_MAX_MS = 150;
    localparam int ILOCK_PULSE_MS = 125;
    localparam int PME_TICK_US = 1;
    localparam int PME_TICK_CYC = PME_TICK_US * CLK_KHZ / 1000;

    typedef enum logic {ILK_IDLE = 1'b0, ILK_HOLD = 1'b1} dhp_ilk_e;
    typedef enum logic {PME_IDLE = 1'b0, PME_WAIT = 1'b1} dhp_pme_e;
endpackage

//--- hw/dhp_sync.sv
// three-stage synchroniser with agreement filter for slot sensor pins
// assumes pins asynchronous to clk; output moves once stages two and three agree
module dhp_sync #(
    parameter int WIDTH = 5
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // pins and filtered result
    input wire logic [WIDTH-1:0] pinIn,
    output logic [WIDTH-1:0] level
);
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
    logic [WIDTH-1:0] stage3;
    logic [WIDTH-1:0] next_level;

    always_comb begin
        for (int i = 0; i < WIDTH; i++) begin
            next_level[i] = (stage2[i] == stage3[i]) ? stage3[i] : level[i];
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            stage1 <= '0;
            stage2 <= '0;
            stage3 <= '0;
            level <= '0;
        end else begin
            stage1 <= pinIn;
            stage2 <= stage1;
            stage3 <= stage2;
            level <= next_level;
        end
    end
endmodule

//--- hw/dhp_port.sv
// hot-plug controller of one downstream port: slot registers, sensors, indicators,
// interlock, automatic power-off, hot-plug interrupt and PM_PME wake with retry
// assumes expander-side pins arrive asynchronous; register port on clk
//
// Local design decisions: strobed register access and the address map.
module dhp_port #(
    parameter int ILOCK_CYC = dhp_pkg::ILOCK_PULSE_MS * (dhp_pkg::CLK_KHZ)
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // register port
    input wire logic [7:0] regAddr,
    input wire logic [31:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [31:0] regRdata,
    // power management
    input wire logic switchD3hot,
    input wire logic d3Cold,
    output logic pmeSend,
    // initialisation sequencing
    input wire logic eepromBusy,
    output logic ioxInitStart,
    // slot sensors from the expander
    input wire logic attentionButtonIn,
    input wire logic presenceDetectIn,
    input wire logic powerFaultIn,
    input wire logic latchSensorIn,
    input wire logic powerGoodIn,
    // slot outputs to the expander
    output logic attentionIndicatorOut,
    output logic powerIndicatorOut,
    output logic powerEnableOut,
    output logic interlockOut,
    // interrupt
    output logic hotPlugIrq
);
    localparam int ILOCK_MIN_CYC = dhp_pkg::ILOCK_MIN_MS * dhp_pkg::CLK_KHZ;
    localparam int ILOCK_MAX_CYC = dhp_pkg::ILOCK_MAX_MS * dhp_pkg::CLK_KHZ;

    localparam int ILOCK_DEF_CYC = dhp_pkg::ILOCK_PULSE_MS * dhp_pkg::CLK_KHZ;

    // short pulses are allowed for simulation; the default must sit in the window
    if (ILOCK_DEF_CYC <= ILOCK_MIN_CYC || ILOCK_DEF_CYC >= ILOCK_MAX_CYC) begin : g_bad_window
        $error("default interlock pulse outside its window");
    end
    if (ILOCK_CYC < 1 || ILOCK_CYC >= 2 ** 24) begin : g_bad_count
        $error("interlock pulse count out of range");
    end

    // register state
    logic [1:0] cap, next_cap;
    logic [10:0] ctl, next_ctl;
    logic [4:0] sts, next_sts;
    logic [11:0] cfg, next_cfg;
    logic [1:0] pmState, next_pmState;
    logic pmeEn, next_pmeEn;
    logic pmeStatus, next_pmeStatus;
    logic [15:0] pmeTo, next_pmeTo;
    logic [31:0] next_regRdata;
    // sensor and event state
    logic [4:0] sensRaw, sens, prevSens, next_prevSens;
    logic primed;
    logic [4:0] evtSet;
    logic busyPrev;
    // interlock timer
    dhp_pkg::dhp_ilk_e ilkState, next_ilkState;
    logic [23:0] ilkCnt, next_ilkCnt;
    logic ilkLevel, next_ilkLevel;
    // pme timer
    dhp_pkg::dhp_pme_e pmeState, next_pmeState;
    logic [15:0] pmeCnt, next_pmeCnt;
    logic [6:0] tickCnt, next_tickCnt;
    logic tick;
    logic next_pmeSend;
    // outputs
    logic powerOn, next_powerOn;
    logic next_irq;

    logic wrCtl, wrSts, eicWrite, latchOpen, inD3hot, pmeOk, wakeReq;

    // sensors reach us through the expander, so treat them as asynchronous
    dhp_sync #(.WIDTH(5)) u_sync (
        .clk(clk),
        .rst(rst),
        .pinIn({powerGoodIn, latchSensorIn, powerFaultIn, presenceDetectIn,
            attentionButtonIn}),
        .level(sensRaw)
    );

    // one inversion bit per signal type
    assign sens = sensRaw ^ cfg[4:0];
    assign latchOpen = sens[3];
    assign wrCtl = regWr && regAddr == dhp_pkg::OFF_SLOTCTL;
    assign wrSts = regWr && regAddr == dhp_pkg::OFF_SLOTSTS;
    assign eicWrite = wrCtl && regWdata[dhp_pkg::CTL_EIC] && cap[dhp_pkg::CAP_HPC];
    assign inD3hot = pmState == dhp_pkg::PM_D3HOT || switchD3hot;
    assign pmeOk = inD3hot && !d3Cold && pmeEn;
    assign tick = tickCnt == 7'h00;

    // events: presence only from the presence input gated by capability
    always_comb begin
        evtSet = 5'h00;
        if (primed && cap[dhp_pkg::CAP_HPC]) begin
            evtSet[dhp_pkg::EV_BTN] = sens[0] && !prevSens[0];
            evtSet[dhp_pkg::EV_PRES] = sens[1] != prevSens[1];
            evtSet[dhp_pkg::EV_FAULT] = sens[2] && !prevSens[2];
            evtSet[dhp_pkg::EV_LATCH] = sens[3] != prevSens[3];
            // configuration loads from EEPROM complete no command
            evtSet[dhp_pkg::EV_CC] = wrCtl && !eepromBusy;
        end
    end

    // command completed is excluded from wake-up
    assign wakeReq = inD3hot && |(evtSet[3:0] & ctl[3:0]);

    // register file
    always_comb begin
        next_cap = cap;
        next_ctl = ctl;
        next_cfg = cfg;
        next_pmState = pmState;
        next_pmeEn = pmeEn;
        next_pmeTo = pmeTo;
        next_pmeStatus = pmeStatus;
        next_prevSens = sens;
        // set wins over a write-one clear
        next_sts = (sts & ~(wrSts ? regWdata[4:0] : 5'h00)) | evtSet;
        if (wakeReq && !d3Cold) begin
            next_pmeStatus = 1'b1;
        end else if (regWr && regAddr == dhp_pkg::OFF_POWER_MGMT_CTRL_STATUS_REG && regWdata[dhp_pkg::PM_STATUS]) begin
            next_pmeStatus = 1'b0;
        end
        if (regWr) begin
            case (regAddr)
                dhp_pkg::OFF_SLOTCAP: next_cap = regWdata[1:0];
                // interlock control is an action bit above these, never stored
                dhp_pkg::OFF_SLOTCTL: next_ctl = regWdata[10:0];
                dhp_pkg::OFF_HPCFG: next_cfg = regWdata[11:0];
                dhp_pkg::OFF_POWER_MGMT_CTRL_STATUS_REG: begin
                    next_pmState = regWdata[1:0];
                    next_pmeEn = regWdata[dhp_pkg::PM_EN];
                end
                dhp_pkg::OFF_PMETMR: next_pmeTo = regWdata[15:0];
                default: next_cap = cap;
            endcase
        end
        next_regRdata = 32'h0000_0000;
        if (regRd) begin
            case (regAddr)
                dhp_pkg::OFF_SLOTCAP: next_regRdata = {30'h0, cap};
                dhp_pkg::OFF_SLOTCTL: next_regRdata = {21'h0, ctl};
                dhp_pkg::OFF_SLOTSTS: begin
                    next_regRdata[4:0] = sts;
                    // latch shown open, or as interlock status instead
                    next_regRdata[dhp_pkg::STS_LATCHST] = !cfg[dhp_pkg::CFG_LATCHILK] && sens[3];
                    next_regRdata[dhp_pkg::STS_ILOCKST] = cfg[dhp_pkg::CFG_LATCHILK] && sens[3];
                    next_regRdata[dhp_pkg::STS_PRESST] = sens[1];
                    next_regRdata[dhp_pkg::STS_PGOOD] = sens[4];
                end
                dhp_pkg::OFF_HPCFG: next_regRdata = {20'h0, cfg};
                dhp_pkg::OFF_POWER_MGMT_CTRL_STATUS_REG: begin
                    next_regRdata = {16'h0, pmeStatus, 6'h00, pmeEn, 6'h00, pmState};
                end
                dhp_pkg::OFF_PMETMR: next_regRdata = {16'h0, pmeTo};
                default: next_regRdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            cap <= dhp_pkg::SLOTCAP_RST;
            ctl <= dhp_pkg::SLOTCTL_RST;
            cfg <= dhp_pkg::HPCFG_RST;
            sts <= 5'h00;
            pmState <= 2'h0;
            pmeEn <= 1'b0;
            pmeStatus <= 1'b0;
            pmeTo <= dhp_pkg::PMETMR_RST;
            prevSens <= 5'h00;
            primed <= 1'b0;
            regRdata <= 32'h0000_0000;
        end else begin
            cap <= next_cap;
            ctl <= next_ctl;
            cfg <= next_cfg;
            sts <= next_sts;
            pmState <= next_pmState;
            pmeEn <= next_pmeEn;
            pmeStatus <= next_pmeStatus;
            pmeTo <= next_pmeTo;
            prevSens <= next_prevSens;
            primed <= 1'b1;
            regRdata <= next_regRdata;
        end
    end

    // interlock: fixed pulse, or invert in toggle mode
    always_comb begin
        next_ilkState = ilkState;
        next_ilkCnt = ilkCnt;
        next_ilkLevel = ilkLevel;
        case (ilkState)
            dhp_pkg::ILK_IDLE: begin
                if (eicWrite && cfg[dhp_pkg::CFG_TOGGLE]) begin
                    next_ilkLevel = !ilkLevel;
                end else if (eicWrite) begin
                    next_ilkLevel = 1'b1;
                    next_ilkCnt = 24'(ILOCK_CYC - 1);
                    next_ilkState = dhp_pkg::ILK_HOLD;
                end
            end
            dhp_pkg::ILK_HOLD: begin
                if (eicWrite && cfg[dhp_pkg::CFG_TOGGLE]) begin
                    next_ilkLevel = !ilkLevel;
                    next_ilkState = dhp_pkg::ILK_IDLE;
                end else if (ilkCnt == 24'h000000) begin
                    next_ilkLevel = 1'b0;
                    next_ilkState = dhp_pkg::ILK_IDLE;
                end else begin
                    next_ilkCnt = ilkCnt - 24'h000001;
                end
            end
            default: next_ilkState = dhp_pkg::ILK_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            ilkState <= dhp_pkg::ILK_IDLE;
            ilkCnt <= 24'h000000;
            ilkLevel <= 1'b0;
        end else begin
            ilkState <= next_ilkState;
            ilkCnt <= next_ilkCnt;
            ilkLevel <= next_ilkLevel;
        end
    end

    // pme send and retry; timer runs on a microsecond enable
    always_comb begin
        next_pmeState = pmeState;
        next_pmeCnt = pmeCnt;
        next_pmeSend = 1'b0;
        next_tickCnt = tick ? 7'(dhp_pkg::PME_TICK_CYC - 1) : tickCnt - 7'h01;
        case (pmeState)
            dhp_pkg::PME_IDLE: begin
                if (wakeReq && pmeOk) begin
                    next_pmeSend = 1'b1;
                    next_pmeCnt = pmeTo;
                    next_pmeState = dhp_pkg::PME_WAIT;
                end
            end
            dhp_pkg::PME_WAIT: begin
                if (!pmeStatus) begin
                    next_pmeState = dhp_pkg::PME_IDLE;
                end else if (tick && pmeCnt <= 16'h0001) begin
                    // retry only where a message may still be sent
                    next_pmeSend = pmeOk;
                    next_pmeCnt = pmeTo;
                end else if (tick) begin
                    next_pmeCnt = pmeCnt - 16'h0001;
                end
            end
            default: next_pmeState = dhp_pkg::PME_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            pmeState <= dhp_pkg::PME_IDLE;
            pmeCnt <= 16'h0000;
            tickCnt <= 7'h00;
            pmeSend <= 1'b0;
        end else begin
            pmeState <= next_pmeState;
            pmeCnt <= next_pmeCnt;
            tickCnt <= next_tickCnt;
            pmeSend <= next_pmeSend;
        end
    end

    // slot power and outputs; power fault is not latched, adapter must hold it
    always_comb begin
        if (cfg[dhp_pkg::CFG_AUTOOFF] && cap[dhp_pkg::CAP_LATCH] && latchOpen) begin
            next_powerOn = 1'b0;
        end else begin
            next_powerOn = !cap[dhp_pkg::CAP_HPC] || !ctl[dhp_pkg::CTL_PCC];
        end
        // interrupt needs enable plus an unmasked event
        next_irq = ctl[dhp_pkg::CTL_HOT_PLUG_INT_ENABLE_BIT] && |(sts & ctl[4:0]);
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            powerOn <= 1'b0;
            hotPlugIrq <= 1'b0;
            busyPrev <= 1'b1;
            ioxInitStart <= 1'b0;
            attentionIndicatorOut <= 1'b0;
            powerIndicatorOut <= 1'b0;
            powerEnableOut <= 1'b0;
            interlockOut <= 1'b0;
        end else begin
            powerOn <= next_powerOn;
            hotPlugIrq <= next_irq;
            busyPrev <= eepromBusy;
            ioxInitStart <= busyPrev && !eepromBusy;
            // blink encodings light the indicator steadily
            attentionIndicatorOut <= (ctl[7:6] == 2'h1 || ctl[7:6] == 2'h2) ^ cfg[5];
            powerIndicatorOut <= (ctl[9:8] == 2'h1 || ctl[9:8] == 2'h2) ^ cfg[6];
            powerEnableOut <= powerOn ^ cfg[7];
            interlockOut <= ilkLevel ^ cfg[8];
        end
    end

    chk_no_cold_pme: assert property (@(posedge clk) disable iff (rst)
        $past(d3Cold) |-> !pmeSend) else $error("pme sent in D3cold");
    chk_pme_in_d3: assert property (@(posedge clk) disable iff (rst)
        pmeSend |-> $past(inD3hot)) else $error("pme outside D3hot");
    chk_pme_retry: assert property (@(posedge clk) disable iff (rst)
        pmeState == dhp_pkg::PME_WAIT && pmeStatus && tick && pmeCnt <= 16'h0001
        && pmeOk |=> pmeSend && pmeCnt == $past(pmeTo)) else $error("pme not resent");
    chk_cap_gates: assert property (@(posedge clk) disable iff (rst)
        !cap[dhp_pkg::CAP_HPC] |-> evtSet == 5'h00 && !eicWrite)
        else $error("event without capability");
    chk_pulse_len: assert property (@(posedge clk) disable iff (rst)
        eicWrite && !cfg[dhp_pkg::CFG_TOGGLE] && ilkState == dhp_pkg::ILK_IDLE
        |=> ilkLevel && ilkCnt == 24'(ILOCK_CYC - 1)) else $error("interlock pulse wrong");
    chk_ilk_toggle: assert property (@(posedge clk) disable iff (rst)
        eicWrite && cfg[dhp_pkg::CFG_TOGGLE] |=> ilkLevel != $past(ilkLevel)
        ##1 interlockOut == $past(ilkLevel ^ cfg[8])) else $error("interlock not toggled");
    chk_eis_zero: assert property (@(posedge clk) disable iff (rst)
        regRd && regAddr == dhp_pkg::OFF_SLOTSTS && !cfg[dhp_pkg::CFG_LATCHILK]
        |=> !regRdata[dhp_pkg::STS_ILOCKST]) else $error("interlock status not zero");
    chk_auto_off: assert property (@(posedge clk) disable iff (rst)
        cfg[dhp_pkg::CFG_AUTOOFF] && cap[dhp_pkg::CAP_LATCH] && latchOpen
        |=> !powerOn ##1 powerEnableOut == cfg[7]) else $error("power not removed");
    chk_cc_quiet: assert property (@(posedge clk) disable iff (rst)
        wrCtl && eepromBusy |=> sts[dhp_pkg::EV_CC] == $past(sts[dhp_pkg::EV_CC]))
        else $error("command completed during load");
    chk_irq_gate: assert property (@(posedge clk) disable iff (rst)
        hotPlugIrq |-> $past(ctl[dhp_pkg::CTL_HOT_PLUG_INT_ENABLE_BIT]) && $past(|(sts & ctl[4:0])))
        else $error("interrupt not gated");
    chk_cc_no_wake: assert property (@(posedge clk) disable iff (rst)
        pmeState == dhp_pkg::PME_IDLE && evtSet == 5'h10 |=> !pmeSend)
        else $error("wake on command completed");
endmodule

//--- test/dhp_slot_model.sv
// slot-side model: expander input bits wired to the slot sensors
// assumes the bench sets the wanted sensor levels; high means asserted
module dhp_slot_model (
    // clock
    input wire logic clk,
    // wanted sensor levels
    input wire logic btnReq,
    input wire logic presReq,
    input wire logic faultReq,
    input wire logic latchReq,
    // power enable as seen at the slot
    input wire logic powerEnableOut,
    // sensor bits
    output logic attentionButtonIn,
    output logic presenceDetectIn,
    output logic powerFaultIn,
    output logic latchSensorIn,
    output logic powerGoodIn
);
    timeunit 1ns;
    timeprecision 1ps;
    logic faultHeld = 1'b0;
    logic pwrSeen = 1'b0;
    // the switch never latches a fault, so the adapter holds it till power moves
    always @(posedge clk) begin
        pwrSeen <= powerEnableOut;
        if (faultReq) begin
            faultHeld <= 1'b1;
        end else if (pwrSeen != powerEnableOut) begin
            faultHeld <= 1'b0;
        end
    end
    assign attentionButtonIn = btnReq;
    assign presenceDetectIn = presReq;
    assign powerFaultIn = faultHeld;
    assign latchSensorIn = latchReq;
    assign powerGoodIn = powerEnableOut;
endmodule

//--- test/tb_downstream_hot_plug_controller.sv
// self-checking bench of one downstream hot-plug port
// assumes a short interlock pulse parameter; slot sensors come from the slot model
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin error_cnt++; \
    $display("ERROR %0t got %h exp %h", $time, a, b); end end
module tb_downstream_hot_plug_controller;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int ILK = 50;
    logic clk = 1'b0, rst = 1'b1, regWr = 1'b0, regRd = 1'b0;
    logic [7:0] regAddr = 8'h00;
    logic [31:0] regWdata = 32'h0, regRdata;
    logic switchD3hot = 1'b0, d3Cold = 1'b0, eepromBusy = 1'b1, pmeSend, ioxInitStart;
    logic btnReq = 1'b0, presReq = 1'b0, faultReq = 1'b0, latchReq = 1'b0;
    logic attBtn, pres, fault, latch, pgood, attInd, pwrInd, pwrEn, ilk, hotPlugIrq;
    int error_cnt = 0, checks_done = 0;
    always #4 clk = ~clk;
    dhp_port #(.ILOCK_CYC(ILK)) i_dhp_port (.clk(clk), .rst(rst), .regAddr(regAddr),
        .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
        .switchD3hot(switchD3hot), .d3Cold(d3Cold), .pmeSend(pmeSend),
        .eepromBusy(eepromBusy), .ioxInitStart(ioxInitStart), .attentionButtonIn(attBtn),
        .presenceDetectIn(pres), .powerFaultIn(fault), .latchSensorIn(latch),
        .powerGoodIn(pgood), .attentionIndicatorOut(attInd), .powerIndicatorOut(pwrInd),
        .powerEnableOut(pwrEn), .interlockOut(ilk), .hotPlugIrq(hotPlugIrq));
    dhp_slot_model i_dhp_slot_model (.clk(clk), .btnReq(btnReq), .presReq(presReq),
        .faultReq(faultReq), .latchReq(latchReq), .powerEnableOut(pwrEn),
        .attentionButtonIn(attBtn), .presenceDetectIn(pres), .powerFaultIn(fault),
        .latchSensorIn(latch), .powerGoodIn(pgood));
    task automatic end_sim;
        if (error_cnt == 0 && checks_done > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        regWr <= 1'b1;
        regAddr <= a;
        regWdata <= d;
        @(posedge clk);
        regWr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge clk);
        regRd <= 1'b0;
        #1 d = regRdata;
    endtask
    function automatic logic sel(input int k);
        case (k)
            0: return ioxInitStart;
            1: return pmeSend;
            2: return hotPlugIrq;
            3: return ilk;
            default: return pwrEn;
        endcase
    endfunction
    // bounded wait for one output to reach a level; running out ends the run
    task automatic waitv(input int k, input logic v, input int lim);
        int n;
        n = 0;
        while (sel(k) !== v) begin
            if (n == lim) begin
                error_cnt++;
                $display("ERROR %0t timeout", $time);
                end_sim();
            end
            @(posedge clk);
            #1 n++;
        end
    endtask
    task automatic quiet(input int n);
        int c;
        c = 0;
        repeat (n) begin
            @(posedge clk);
            #1 c += int'(pmeSend === 1'b1);
        end
        `CHK(c, 0)
    endtask
    task automatic t_init;
        logic [31:0] d;
        rd(dhp_pkg::OFF_SLOTCTL, d);
        `CHK(d[11:0], 12'h400)
        rd(dhp_pkg::OFF_PMETMR, d);
        `CHK(d[15:0], 16'h0064)
        rd(8'h1c, d);
        `CHK(d, 32'h0)
        wr(dhp_pkg::OFF_SLOTCAP, 32'h3);
        wr(dhp_pkg::OFF_SLOTCTL, 32'h400);
        rd(dhp_pkg::OFF_SLOTSTS, d);
        `CHK(d[dhp_pkg::EV_CC], 1'b0)
        `CHK(ioxInitStart, 1'b0)
        eepromBusy <= 1'b0;
        waitv(0, 1'b1, 4);
    endtask
    task automatic t_power;
        logic [31:0] d;
        `CHK(pwrEn, 1'b0)
        wr(dhp_pkg::OFF_SLOTCTL, 32'h0);
        waitv(4, 1'b1, 4);
        rd(dhp_pkg::OFF_SLOTSTS, d);
        `CHK(d[dhp_pkg::EV_CC], 1'b1)
        wr(dhp_pkg::OFF_HPCFG, 32'h800);
        latchReq <= 1'b1;
        waitv(4, 1'b0, 8);
        latchReq <= 1'b0;
        waitv(4, 1'b1, 8);
        wr(dhp_pkg::OFF_HPCFG, 32'h0);
        wr(dhp_pkg::OFF_SLOTSTS, 32'h1f);
        wr(dhp_pkg::OFF_SLOTCAP, 32'h0);
        presReq <= 1'b1;
        cyc(8);
        rd(dhp_pkg::OFF_SLOTSTS, d);
        `CHK(d[4:0], 5'h00)
        presReq <= 1'b0;
        cyc(8);
        wr(dhp_pkg::OFF_SLOTCAP, 32'h3);
    endtask
    task automatic t_sense;
        logic [31:0] d;
        latchReq <= 1'b1;
        presReq <= 1'b1;
        wr(dhp_pkg::OFF_HPCFG, 32'h400);
        cyc(8);
        rd(dhp_pkg::OFF_SLOTSTS, d);
        `CHK(d[8:5], 4'he)
        wr(dhp_pkg::OFF_HPCFG, 32'h002);
        cyc(8);
        rd(dhp_pkg::OFF_SLOTSTS, d);
        `CHK(d[7:5], 3'h1)
        wr(dhp_pkg::OFF_HPCFG, 32'h0);
        latchReq <= 1'b0;
        presReq <= 1'b0;
        cyc(8);
    endtask
    task automatic t_irq;
        wr(dhp_pkg::OFF_SLOTSTS, 32'h1f);
        wr(dhp_pkg::OFF_SLOTCTL, 32'h08);
        presReq <= 1'b1;
        cyc(8);
        `CHK(hotPlugIrq, 1'b0)
        wr(dhp_pkg::OFF_SLOTCTL, 32'h28);
        waitv(2, 1'b1, 4);
        wr(dhp_pkg::OFF_SLOTSTS, 32'h08);
        waitv(2, 1'b0, 4);
        presReq <= 1'b0;
        cyc(8);
        wr(dhp_pkg::OFF_SLOTSTS, 32'h1f);
        wr(dhp_pkg::OFF_SLOTCTL, 32'h140);
        cyc(3);
        `CHK({attInd, pwrInd}, 2'b11)
    endtask
    task automatic t_ilk;
        int n;
        wr(dhp_pkg::OFF_SLOTCTL, 32'h800);
        waitv(3, 1'b1, 4);
        n = 0;
        while (ilk === 1'b1 && n < ILK + 10) begin
            @(posedge clk);
            #1 n++;
        end
        `CHK(n, ILK)
        wr(dhp_pkg::OFF_HPCFG, 32'h200);
        wr(dhp_pkg::OFF_SLOTCTL, 32'h800);
        waitv(3, 1'b1, 4);
        cyc(ILK + 5);
        `CHK(ilk, 1'b1)
        wr(dhp_pkg::OFF_SLOTCTL, 32'h800);
        waitv(3, 1'b0, 4);
        wr(dhp_pkg::OFF_HPCFG, 32'h0);
    endtask
    task automatic t_pme;
        wr(dhp_pkg::OFF_SLOTSTS, 32'h1f);
        wr(dhp_pkg::OFF_PMETMR, 32'h1);
        wr(dhp_pkg::OFF_SLOTCTL, 32'h02);
        wr(dhp_pkg::OFF_POWER_MGMT_CTRL_STATUS_REG, 32'h103);
        faultReq <= 1'b1;
        @(posedge clk);
        faultReq <= 1'b0;
        waitv(1, 1'b1, 10);
        waitv(1, 1'b0, 2);
        waitv(1, 1'b1, 300);
        wr(dhp_pkg::OFF_POWER_MGMT_CTRL_STATUS_REG, 32'h8103);
        quiet(300);
        wr(dhp_pkg::OFF_SLOTCTL, 32'h1a);
        quiet(20);
        d3Cold <= 1'b1;
        presReq <= 1'b1;
        quiet(20);
        wr(dhp_pkg::OFF_POWER_MGMT_CTRL_STATUS_REG, 32'h8100);
        d3Cold <= 1'b0;
        switchD3hot <= 1'b1;
        presReq <= 1'b0;
        waitv(1, 1'b1, 10);
        switchD3hot <= 1'b0;
        wr(dhp_pkg::OFF_POWER_MGMT_CTRL_STATUS_REG, 32'h8100);
    endtask
    initial begin
        cyc(2);
        rst <= 1'b0;
        t_init();
        t_power();
        t_sense();
        t_irq();
        t_ilk();
        t_pme();
        end_sim();
    end
endmodule
